// ===== logic/tevg_chan.sv
/*
  One capture/compare channel: flag, over-capture flag and value register.
  Assumes the counter and the event strobes come from the same clock.
*/
module tevg_chan (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  mode_sel,
  input  wire logic        sw_evt,
  input  wire logic        cmp_hit,
  input  wire logic [15:0] cnt,
  input  wire logic        clr_flag,
  input  wire logic        clr_of,
  input  wire logic        cv_we,
  input  wire logic [15:0] cv_mask,
  input  wire logic [15:0] cv_wdata,
  output logic             evt,
  output logic             flag,
  output logic             ovf,
  output logic [15:0]      cv
);
  logic        is_input;
  logic        capture;
  logic        flag_q;
  logic        flag_d;
  logic        ovf_q;
  logic        ovf_d;
  logic [15:0] cv_q;
  logic [15:0] cv_d;

  // Channel event, flags set win over clears, capture wins over writes
  always_comb
  begin
    is_input = (mode_sel != tevg_pkg::MS_OUTPUT);
    capture  = sw_evt && is_input;
    evt      = sw_evt || (cmp_hit && !is_input);
    flag_d   = evt || (flag_q && !clr_flag);
    ovf_d    = (capture && flag_q) || (ovf_q && !clr_of);
    cv_d     = cv_q;
    if (capture)
      cv_d = cnt;
    else if (cv_we)
      cv_d = (cv_q & ~cv_mask) | (cv_wdata & cv_mask);
  end

  // Channel state registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b0;
      ovf_q  <= 1'b0;
      cv_q   <= tevg_pkg::RST_REG;
    end
    else
    begin
      flag_q <= flag_d;
      ovf_q  <= ovf_d;
      cv_q   <= cv_d;
    end
  end

  assign flag = flag_q;
  assign ovf  = ovf_q;
  assign cv   = cv_q;

  a_chan_capture: assert property (@(posedge clk) disable iff (!rst_n)
    sw_evt && (mode_sel != tevg_pkg::MS_OUTPUT) |=> cv_q == $past(cnt))
    else $error("software capture did not copy the counter");

  a_chan_overcap: assert property (@(posedge clk) disable iff (!rst_n)
    sw_evt && (mode_sel != tevg_pkg::MS_OUTPUT) && flag_q |=> ovf_q)
    else $error("over-capture flag not set");

  a_chan_outmode: assert property (@(posedge clk) disable iff (!rst_n)
    sw_evt && (mode_sel == tevg_pkg::MS_OUTPUT) && !cv_we |=> $stable(cv_q) && flag_q)
    else $error("compare channel captured or missed its flag");

  c_chan_overcap: cover property (@(posedge clk) disable iff (!rst_n)
    sw_evt && (mode_sel != tevg_pkg::MS_OUTPUT) && flag_q);

endmodule // tevg_chan

// ===== logic/tevg_pkg.sv
/*
  Constants, register map, field positions and carrier types of the timer
  software event generation block.
  Assumes a classic Wishbone master with 32-bit data and byte addresses.
*/
// What this block does
// - A one written to bit 6 of the event register sets the trigger flag, and its request follows when enabled.
// - Event bits are set only by a software write and clear themselves once the event is made, so reads give zero.
// - Channels 0 to 3 each have their own capture/compare event bit, at positions 1 to 4.
// - A channel event bit sets that channel's capture/compare flag, with its request when enabled.
// - In input mode a software capture copies the counter into the channel's value register.
// - A software capture in input mode while the channel flag is already set also sets the over-capture flag.
// - A one at bit 0 clears the counter when up or center-aligned counting is chosen.
// - In down counting the software update loads the counter with the auto-reload value.
// - The software update clears the prescaler counter in the same step.
// - A zero written to any event bit does nothing.
// - DMA requests go out only when their enable bit is one, interrupts only when theirs is one.
// - Mode selection 00 makes a channel a compare output, any other value a capture input.
package tevg_pkg;

  // Register byte offsets
  localparam logic [7:0]  OFF_CTL    = 8'h00;
  localparam logic [7:0]  OFF_INTEN  = 8'h0c;
  localparam logic [7:0]  OFF_STAT   = 8'h10;
  localparam logic [7:0]  OFF_SWEVG  = 8'h14;
  localparam logic [7:0]  OFF_CHCTL0 = 8'h18;
  localparam logic [7:0]  OFF_CHCTL1 = 8'h1c;
  localparam logic [7:0]  OFF_CNT    = 8'h24;
  localparam logic [7:0]  OFF_PSC    = 8'h28;
  localparam logic [7:0]  OFF_CAR    = 8'h2c;
  localparam logic [7:0]  OFF_CV0    = 8'h34;
  localparam logic [7:0]  OFF_CLR    = 8'h50;
  localparam logic [7:0]  CV_STRIDE  = 8'h04;

  // Field positions
  localparam int          BIT_UPG    = 0;
  localparam int          BIT_CHAN0_EVENT_GENERATE   = 1;
  localparam int          BIT_TRIGGER_EVENT_GENERATE   = 6;
  localparam int          BIT_OF0    = 9;
  localparam int          BIT_UPDEN  = 8;
  localparam int          BIT_CH0DEN = 9;
  localparam int          BIT_TRIGGER_DMA_ENABLE = 14;
  localparam int          BIT_CEN    = 0;
  localparam int          BIT_DIR    = 4;
  localparam int          BIT_CAM    = 5;
  localparam int          MS_HI_POS  = 8;
  localparam int          NCHAN      = 4;

  // Reset values and masks
  localparam logic [15:0] RST_REG    = 16'h0000;
  localparam logic [15:0] RST_CAR    = 16'hffff;
  localparam logic [15:0] SWEVG_MASK = 16'h005f;
  localparam logic [15:0] ONE16      = 16'h0001;
  localparam logic [1:0]  MS_OUTPUT  = 2'b00;

  // Counting modes held in the control register
  typedef enum logic [1:0] {
    TEVG_EDGE = 2'b00,
    TEVG_CA1  = 2'b01,
    TEVG_CA2  = 2'b10,
    TEVG_CA3  = 2'b11
  } tevg_cam_e;

  // One set of events, one bit per source
  typedef struct packed {
    logic       trg;
    logic [3:0] ch;
    logic       up;
  } tevg_evt_s;

endpackage

// ===== logic/tevg_presc.sv
/*
  Prescaler divider: a one-cycle counting enable every psc+1 clocks.
  Assumes the same clock and reset as the timer top.
*/
module tevg_presc (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] psc,
  input  wire logic        run,
  input  wire logic        clr,
  output logic             tick
);
  logic [15:0] div_q;
  logic [15:0] div_d;

  // Next divider value, clear wins over counting
  always_comb
  begin
    div_d = div_q;
    if (clr)
      div_d = tevg_pkg::RST_REG;
    else if (run)
      div_d = (div_q == psc) ? tevg_pkg::RST_REG : div_q + tevg_pkg::ONE16;
  end

  // Divider register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= tevg_pkg::RST_REG;
    else
      div_q <= div_d;
  end

  assign tick = run && !clr && (div_q == psc);

  // A divide by one may tick right after the clear
  a_presc_clear: assert property (@(posedge clk) disable iff (!rst_n)
    clr |=> (div_q == tevg_pkg::RST_REG) && (!tick || (psc == tevg_pkg::RST_REG)))
    else $error("prescaler not cleared by update");

endmodule // tevg_presc

// ===== logic/tevg_top.sv
/*
  Timer with software event generation, reached over classic Wishbone.
  Holds the counter, control, enable, status, clear and event registers.
  Assumes a single 250 MHz clock and an asynchronous active-low reset.
*/
module tevg_top (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ,
  output logic             DMA_UP,
  output logic [3:0]       DMA_CH,
  output logic             DMA_TRG
);
  localparam int N = tevg_pkg::NCHAN;

  logic                 req;
  logic                 wr;
  logic [15:0]          wmask;
  logic [15:0]          wdata;
  logic [15:0]          clr_w;
  logic                 ack_q;
  logic                 ack_d;
  logic [31:0]          rdat_q;
  logic [31:0]          rdat_d;
  logic [15:0]          ctl_q;
  logic [15:0]          ctl_d;
  logic [15:0]          inten_q;
  logic [15:0]          inten_d;
  logic [15:0]          chctl0_q;
  logic [15:0]          chctl0_d;
  logic [15:0]          chctl1_q;
  logic [15:0]          chctl1_d;
  logic [15:0]          psc_q;
  logic [15:0]          psc_d;
  logic [15:0]          car_q;
  logic [15:0]          car_d;
  logic [15:0]          cnt_q;
  logic [15:0]          cnt_d;
  logic [15:0]          swevg_q;
  logic [15:0]          swevg_d;
  logic                 trg_flag_q;
  logic                 trg_flag_d;
  logic                 up_flag_q;
  logic                 up_flag_d;
  logic                 irq_q;
  logic                 irq_d;
  logic [5:0]           dma_q;
  logic [5:0]           dma_d;
  logic                 tick;
  logic                 running;
  logic                 down;
  logic                 hw_up;
  logic [15:0]          status;
  tevg_pkg::tevg_evt_s  sw;
  tevg_pkg::tevg_evt_s  evt;
  logic [N-1:0]         ch_evt;
  logic [N-1:0]         ch_flag;
  logic [N-1:0]         ch_ovf;
  logic [N-1:0]         cmp_hit;
  logic [N-1:0]         cv_we;
  logic [1:0]           mode [N];
  logic [15:0]          cv   [N];

  // Bus request decode and byte-lane merge
  always_comb
  begin
    req   = WB_CYC_I && WB_STB_I && !ack_q;
    wr    = req && WB_WE_I;
    wmask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    wdata = WB_DAT_I[15:0];
    clr_w = (wr && WB_ADR_I == tevg_pkg::OFF_CLR) ? (wdata & wmask) : tevg_pkg::RST_REG;
  end

  // Software events are taken from the self-clearing event register
  always_comb
  begin
    sw.up  = swevg_q[tevg_pkg::BIT_UPG];
    sw.ch  = swevg_q[tevg_pkg::BIT_CHAN0_EVENT_GENERATE +: N];
    sw.trg = swevg_q[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE];
    // Reserved event bits are masked off, whatever software writes
    swevg_d = tevg_pkg::RST_REG;
    if (wr && WB_ADR_I == tevg_pkg::OFF_SWEVG)
      swevg_d = wdata & wmask & tevg_pkg::SWEVG_MASK;
  end

  // Channel mode fields and compare matches
  always_comb
  begin
    mode[0] = chctl0_q[1:0];
    mode[1] = chctl0_q[tevg_pkg::MS_HI_POS +: 2];
    mode[2] = chctl1_q[1:0];
    mode[3] = chctl1_q[tevg_pkg::MS_HI_POS +: 2];
    for (int i = 0; i < N; i++)
    begin
      cmp_hit[i] = tick && (cnt_q == cv[i]);
      cv_we[i]   = wr && (WB_ADR_I == tevg_pkg::OFF_CV0 + 8'(i) * tevg_pkg::CV_STRIDE);
    end
  end

  // Prescaler divider, cleared by the software update
  tevg_presc u_presc (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .psc   (psc_q),
    .run   (running),
    .clr   (sw.up),
    .tick  (tick)
  );

  // Four capture/compare channels
  for (genvar g = 0; g < N; g++)
  begin : g_chan
    tevg_chan u_chan (
      .clk      (REF_CLK),
      .rst_n    (RST_N),
      .mode_sel (mode[g]),
      .sw_evt   (sw.ch[g]),
      .cmp_hit  (cmp_hit[g]),
      .cnt      (cnt_q),
      .clr_flag (clr_w[tevg_pkg::BIT_CHAN0_EVENT_GENERATE + g]),
      .clr_of   (clr_w[tevg_pkg::BIT_OF0 + g]),
      .cv_we    (cv_we[g]),
      .cv_mask  (wmask),
      .cv_wdata (wdata),
      .evt      (ch_evt[g]),
      .flag     (ch_flag[g]),
      .ovf      (ch_ovf[g]),
      .cv       (cv[g])
    );
  end

  // Counter next value, software update has the last word
  always_comb
  begin
    running = ctl_q[tevg_pkg::BIT_CEN];
    down    = ctl_q[tevg_pkg::BIT_DIR] &&
              (tevg_pkg::tevg_cam_e'(ctl_q[tevg_pkg::BIT_CAM +: 2]) == tevg_pkg::TEVG_EDGE);
    hw_up   = 1'b0;
    cnt_d   = cnt_q;
    if (wr && WB_ADR_I == tevg_pkg::OFF_CNT)
      cnt_d = (cnt_q & ~wmask) | (wdata & wmask);
    else if (tick)
    begin
      if (down)
      begin
        hw_up = (cnt_q == tevg_pkg::RST_REG);
        cnt_d = hw_up ? car_q : cnt_q - tevg_pkg::ONE16;
      end
      else
      begin
        hw_up = (cnt_q == car_q);
        cnt_d = hw_up ? tevg_pkg::RST_REG : cnt_q + tevg_pkg::ONE16;
      end
    end
    if (sw.up)
      cnt_d = down ? car_q : tevg_pkg::RST_REG;
  end

  // All events of one write act in the same cycle
  always_comb
  begin
    evt.up     = sw.up || hw_up;
    evt.ch     = ch_evt;
    evt.trg    = sw.trg;
    up_flag_d  = evt.up || (up_flag_q && !clr_w[tevg_pkg::BIT_UPG]);
    trg_flag_d = evt.trg || (trg_flag_q && !clr_w[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE]);
    status     = tevg_pkg::RST_REG;
    status[tevg_pkg::BIT_UPG]          = up_flag_q;
    status[tevg_pkg::BIT_CHAN0_EVENT_GENERATE +: N]    = ch_flag;
    status[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE]         = trg_flag_q;
    status[tevg_pkg::BIT_OF0 +: N]     = ch_ovf;
  end

  // Interrupt level and DMA request pulses, each gated by its enable
  always_comb
  begin
    irq_d = |(status[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE:0] & inten_q[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE:0]);
    dma_d = {evt.trg && inten_q[tevg_pkg::BIT_TRIGGER_DMA_ENABLE],
             evt.ch & inten_q[tevg_pkg::BIT_CH0DEN +: N],
             evt.up && inten_q[tevg_pkg::BIT_UPDEN]};
  end

  // Register writes and read mux, unmapped reads return zero
  always_comb
  begin
    ctl_d    = ctl_q;
    inten_d  = inten_q;
    chctl0_d = chctl0_q;
    chctl1_d = chctl1_q;
    psc_d    = psc_q;
    car_d    = car_q;
    ack_d    = req;
    rdat_d   = 32'h0000_0000;
    if (wr)
    begin
      case (WB_ADR_I)
        tevg_pkg::OFF_CTL:    ctl_d    = (ctl_q & ~wmask) | (wdata & wmask);
        tevg_pkg::OFF_INTEN:  inten_d  = (inten_q & ~wmask) | (wdata & wmask);
        tevg_pkg::OFF_CHCTL0: chctl0_d = (chctl0_q & ~wmask) | (wdata & wmask);
        tevg_pkg::OFF_CHCTL1: chctl1_d = (chctl1_q & ~wmask) | (wdata & wmask);
        tevg_pkg::OFF_PSC:    psc_d    = (psc_q & ~wmask) | (wdata & wmask);
        tevg_pkg::OFF_CAR:    car_d    = (car_q & ~wmask) | (wdata & wmask);
        default:              ctl_d    = ctl_q;
      endcase
    end
    if (req && !WB_WE_I)
    begin
      case (WB_ADR_I)
        tevg_pkg::OFF_CTL:    rdat_d[15:0] = ctl_q;
        tevg_pkg::OFF_INTEN:  rdat_d[15:0] = inten_q;
        tevg_pkg::OFF_STAT:   rdat_d[15:0] = status;
        tevg_pkg::OFF_SWEVG:  rdat_d[15:0] = swevg_q;
        tevg_pkg::OFF_CHCTL0: rdat_d[15:0] = chctl0_q;
        tevg_pkg::OFF_CHCTL1: rdat_d[15:0] = chctl1_q;
        tevg_pkg::OFF_CNT:    rdat_d[15:0] = cnt_q;
        tevg_pkg::OFF_PSC:    rdat_d[15:0] = psc_q;
        tevg_pkg::OFF_CAR:    rdat_d[15:0] = car_q;
        default:
        begin
          for (int i = 0; i < N; i++)
            if (WB_ADR_I == tevg_pkg::OFF_CV0 + 8'(i) * tevg_pkg::CV_STRIDE)
              rdat_d[15:0] = cv[i];
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_q      <= 1'b0;
      rdat_q     <= 32'h0000_0000;
      ctl_q      <= tevg_pkg::RST_REG;
      inten_q    <= tevg_pkg::RST_REG;
      chctl0_q   <= tevg_pkg::RST_REG;
      chctl1_q   <= tevg_pkg::RST_REG;
      psc_q      <= tevg_pkg::RST_REG;
      car_q      <= tevg_pkg::RST_CAR;
      cnt_q      <= tevg_pkg::RST_REG;
      swevg_q    <= tevg_pkg::RST_REG;
      trg_flag_q <= 1'b0;
      up_flag_q  <= 1'b0;
      irq_q      <= 1'b0;
      dma_q      <= 6'h00;
    end
    else
    begin
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
      ctl_q      <= ctl_d;
      inten_q    <= inten_d;
      chctl0_q   <= chctl0_d;
      chctl1_q   <= chctl1_d;
      psc_q      <= psc_d;
      car_q      <= car_d;
      cnt_q      <= cnt_d;
      swevg_q    <= swevg_d;
      trg_flag_q <= trg_flag_d;
      up_flag_q  <= up_flag_d;
      irq_q      <= irq_d;
      dma_q      <= dma_d;
    end
  end

  // Outputs
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;
  assign IRQ      = irq_q;
  assign DMA_UP   = dma_q[0];
  assign DMA_CH   = dma_q[4:1];
  assign DMA_TRG  = dma_q[5];

  a_trg_flag_set: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    swevg_q[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE] |=> trg_flag_q)
    else $error("trigger event did not set the trigger flag");

  a_evt_selfclear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (swevg_q != tevg_pkg::RST_REG) |-> $past(wr && WB_ADR_I == tevg_pkg::OFF_SWEVG))
    else $error("event bit held without a fresh write");

  a_up_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    swevg_q[tevg_pkg::BIT_UPG] && !down |=> cnt_q == tevg_pkg::RST_REG)
    else $error("software update did not clear the counter");

  a_up_reload: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    swevg_q[tevg_pkg::BIT_UPG] && down |=> cnt_q == $past(car_q))
    else $error("software update did not load the reload value");

  a_zero_noevt: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    wr && WB_ADR_I == tevg_pkg::OFF_SWEVG && !wdata[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE] |=>
      !swevg_q[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE] ##1 (!trg_flag_q || $past(trg_flag_q, 2)))
    else $error("zero write produced a trigger event");

  a_dma_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (DMA_TRG |-> $past(inten_q[tevg_pkg::BIT_TRIGGER_DMA_ENABLE])) and
    (DMA_CH[0] |-> $past(inten_q[tevg_pkg::BIT_CH0DEN])))
    else $error("DMA request without its enable");

  a_irq_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    IRQ |-> $past(|(status[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE:0] & inten_q[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE:0])))
    else $error("interrupt without an enabled flag");

  a_all_together: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    swevg_q[tevg_pkg::BIT_TRIGGER_EVENT_GENERATE] && swevg_q[tevg_pkg::BIT_CHAN0_EVENT_GENERATE] |=> trg_flag_q && ch_flag[0])
    else $error("events of one write not made together");

  a_chan_flags: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    swevg_q[tevg_pkg::BIT_CHAN0_EVENT_GENERATE + N - 1] |=> ch_flag[N-1])
    else $error("channel 3 event did not set its flag");

  c_trg_evt:  cover property (@(posedge REF_CLK) disable iff (!RST_N) swevg_q[6] && inten_q[6]);
  c_up_down:  cover property (@(posedge REF_CLK) disable iff (!RST_N) swevg_q[0] && down);
  c_multi:    cover property (@(posedge REF_CLK) disable iff (!RST_N) swevg_q == 16'h005f);
  c_overcap:  cover property (@(posedge REF_CLK) disable iff (!RST_N) $rose(ch_ovf[0]));

endmodule // tevg_top

// ===== verif/tb_tevg_top.sv
/*
  Self-checking bench for the timer software event generation block.
  Assumes the design top answers every classic Wishbone access one cycle after taking it.
*/
module tb_tevg_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h3;
  logic [31:0] wdat  = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic        dma_up;
  logic [3:0]  dma_ch;
  logic        dma_trg;
  int          error_cnt = 0;
  int          compares  = 0;
  int          n_trg     = 0;
  int          n_up      = 0;
  logic [3:0]  ch_seen   = 4'h0;
  logic [31:0] q;

  tevg_top i_dut (
    .REF_CLK  (clk),
    .RST_N    (rst_n),
    .WB_CYC_I (cyc),
    .WB_STB_I (stb),
    .WB_WE_I  (we),
    .WB_ADR_I (adr),
    .WB_SEL_I (sel),
    .WB_DAT_I (wdat),
    .WB_DAT_O (rdat),
    .WB_ACK_O (ack),
    .IRQ      (irq),
    .DMA_UP   (dma_up),
    .DMA_CH   (dma_ch),
    .DMA_TRG  (dma_trg)
  );

  // Clock of 4 ns period
  initial
  begin
    forever #2 clk = ~clk;
  end

  // Counts request pulses and the channel set seen in one cycle
  always @(posedge clk)
  begin
    if (dma_trg === 1'b1) n_trg <= n_trg + 1;
    if (dma_up === 1'b1) n_up <= n_up + 1;
    if (dma_ch !== 4'h0) ch_seen <= dma_ch;
  end

  // Verdict and end of run
  task automatic results();
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Compares one value with its expectation
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [15:0] d,
                          output logic [31:0] r);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h3;
    wdat <= {16'h0000, d};
    // Wait for ack sampled high; only the watchdog ends a hang
    do
      @(posedge clk);
    while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    wb_cycle(1'b1, a, d, r);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] r;
    wb_cycle(1'b0, a, 16'h0000, r);
    check(name, r, {16'h0000, exp});
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end

  // Main sequence; 8'h14 is the event register, 8'h18 channel control 0
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    check("irq at reset", {31'h0, irq}, 32'h0000_0000);
    rd("event reg reset", 8'h14, 16'h0000);
    rd("chan ctl reset", 8'h18, 16'h0000);
    rd("status reset", tevg_pkg::OFF_STAT, 16'h0000);
    rd("reload reset", tevg_pkg::OFF_CAR, 16'hffff);
    rd("unmapped", 8'h80, 16'h0000);
    // Trigger event, interrupt without and with its request enable
    wr(tevg_pkg::OFF_INTEN, 16'h0040);
    wr(8'h14, 16'h0040);
    rd("status trg", tevg_pkg::OFF_STAT, 16'h0040);
    rd("event self clear", 8'h14, 16'h0000);
    repeat (3) @(posedge clk);
    check("irq trg", {31'h0, irq}, 32'h0000_0001);
    check("trg dma off", n_trg, 32'h0000_0000);
    wr(tevg_pkg::OFF_INTEN, 16'h0000);
    repeat (3) @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(tevg_pkg::OFF_INTEN, 16'h4040);
    wr(8'h14, 16'h0040);
    repeat (3) @(posedge clk);
    check("irq enabled", {31'h0, irq}, 32'h0000_0001);
    check("trg dma on", n_trg, 32'h0000_0001);
    wr(tevg_pkg::OFF_CLR, 16'h0040);
    repeat (3) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    // Zero writes make nothing; status is read-only
    wr(8'h14, 16'h0000);
    wr(tevg_pkg::OFF_STAT, 16'hffff);
    repeat (3) @(posedge clk);
    rd("status zero write", tevg_pkg::OFF_STAT, 16'h0000);
    check("no trg dma", n_trg, 32'h0000_0001);
    check("no up dma", n_up, 32'h0000_0000);
    // All four channels in input mode, captured in one write
    wr(8'h18, 16'h0201);
    rd("chan ctl rw", 8'h18, 16'h0201);
    wr(tevg_pkg::OFF_CHCTL1, 16'h0101);
    wr(tevg_pkg::OFF_CNT, 16'h1234);
    wr(tevg_pkg::OFF_INTEN, 16'h1e00);
    wr(8'h14, 16'h001e);
    rd("status chans", tevg_pkg::OFF_STAT, 16'h001e);
    for (int i = 0; i < 4; i++)
      rd("capture", tevg_pkg::OFF_CV0 + 8'(i * 4), 16'h1234);
    check("chan dma together", {28'h0, ch_seen}, 32'h0000_000f);
    // Second capture on a set flag raises over-capture
    wr(tevg_pkg::OFF_CNT, 16'h0055);
    wr(8'h14, 16'h0002);
    rd("status overcap", tevg_pkg::OFF_STAT, 16'h021e);
    rd("capture again", tevg_pkg::OFF_CV0, 16'h0055);
    // Channel 2 as compare output, channel 3 as capture input
    wr(tevg_pkg::OFF_CLR, 16'h1e1e);
    wr(tevg_pkg::OFF_CHCTL1, 16'h0300);
    wr(tevg_pkg::OFF_CNT, 16'h0077);
    wr(8'h14, 16'h0018);
    rd("status out in", tevg_pkg::OFF_STAT, 16'h0018);
    rd("no capture out", tevg_pkg::OFF_CV0 + 8'h08, 16'h1234);
    rd("capture in", tevg_pkg::OFF_CV0 + 8'h0c, 16'h0077);
    // Update event in up, down and center-aligned counting
    wr(tevg_pkg::OFF_INTEN, 16'h0100);
    wr(tevg_pkg::OFF_CNT, 16'h0500);
    wr(8'h14, 16'h0001);
    rd("cnt up update", tevg_pkg::OFF_CNT, 16'h0000);
    rd("status update", tevg_pkg::OFF_STAT, 16'h0019);
    check("up dma", n_up, 32'h0000_0001);
    wr(tevg_pkg::OFF_CTL, 16'h0010);
    wr(tevg_pkg::OFF_CAR, 16'h0300);
    wr(tevg_pkg::OFF_CNT, 16'h0010);
    wr(8'h14, 16'h0001);
    rd("cnt down update", tevg_pkg::OFF_CNT, 16'h0300);
    wr(tevg_pkg::OFF_CTL, 16'h0020);
    wr(tevg_pkg::OFF_CNT, 16'h0044);
    wr(8'h14, 16'h0001);
    rd("cnt center update", tevg_pkg::OFF_CNT, 16'h0000);
    // Update in mid-prescale restarts the divide by 256
    wr(tevg_pkg::OFF_CTL, 16'h0000);
    wr(tevg_pkg::OFF_CAR, 16'hffff);
    wr(tevg_pkg::OFF_PSC, 16'h00ff);
    wr(8'h14, 16'h0001);
    wr(tevg_pkg::OFF_CTL, 16'h0001);
    repeat (150) @(posedge clk);
    wr(8'h14, 16'h0001);
    repeat (200) @(posedge clk);
    rd("presc cleared", tevg_pkg::OFF_CNT, 16'h0000);
    repeat (100) @(posedge clk);
    rd("presc tick", tevg_pkg::OFF_CNT, 16'h0001);
    results();
  end

endmodule // tb_tevg_top
